/* hdl/tcb_ctrl.v */
// Transmit channel enable latches, self-test control and code selection
`timescale 1ns/1ps
`include "tcb_regs.vh"
module tcb_ctrl #(
  parameter NUM_CH = `TCB_NUM_CH,
  parameter SETTLE_CYC = `TCB_SETTLE_CYC
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire device_reset_n_i,
  input wire out_latch_enable_i,
  input wire bist_latch_enable_i,
  input wire [2*NUM_CH-1:0] enable_select_bus_i,
  input wire [2*NUM_CH-1:0] tx_ctrl_in_i,
  input wire [8*NUM_CH-1:0] tx_data_in_i,
  input wire special_code_select_i,
  input wire per_channel_mode_i,
  input wire atomic_sync_i,
  input wire reference_clock_in_rate_select_i,
  input wire [1:0] input_clock_select_i,
  input wire [1:0] speed_range_select_i,
  output wire [2*NUM_CH-1:0] driver_enable_o,
  output wire [NUM_CH-1:0] channel_power_o,
  output wire [NUM_CH-1:0] bist_active_o,
  output reg [10*NUM_CH-1:0] char_out_o,
  output reg [2*NUM_CH-1:0] char_kind_o,
  output reg [NUM_CH-1:0] sync_active_o,
  output reg [4*NUM_CH-1:0] sync_index_o,
  output reg [4:0] clock_multiplier_o,
  output reg [1:0] speed_range_o,
  output reg mode_invalid_o,
  output reg settling_o,
  output reg [5:0] scan_tri_bits_o
);
  // Two-stage synchronisers for every pin input
  reg [2*NUM_CH-1:0] sel_s1_reg, sel_s2_reg;
  reg [2*NUM_CH-1:0] ctl_s1_reg, ctl_s2_reg;
  reg [8*NUM_CH-1:0] dat_s1_reg, dat_s2_reg;
  reg [6:0] misc_s1_reg, misc_s2_reg;
  reg [5:0] tri_s1_reg, tri_s2_reg;
  wire rst_n_pin, ole_pin, ble_pin, special_code_select_pin, pcm_pin, atom_pin, rate_pin;
  wire [1:0] ckin_pin, spd_pin;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      sel_s1_reg <= {2*NUM_CH{1'b0}};
      sel_s2_reg <= {2*NUM_CH{1'b0}};
      ctl_s1_reg <= {2*NUM_CH{1'b0}};
      ctl_s2_reg <= {2*NUM_CH{1'b0}};
      dat_s1_reg <= {8*NUM_CH{1'b0}};
      dat_s2_reg <= {8*NUM_CH{1'b0}};
      misc_s1_reg <= 7'h01;
      misc_s2_reg <= 7'h01;
      tri_s1_reg <= 6'h00;
      tri_s2_reg <= 6'h00;
    end else if (ce_i) begin
      sel_s1_reg <= enable_select_bus_i;
      sel_s2_reg <= sel_s1_reg;
      ctl_s1_reg <= tx_ctrl_in_i;
      ctl_s2_reg <= ctl_s1_reg;
      dat_s1_reg <= tx_data_in_i;
      dat_s2_reg <= dat_s1_reg;
      misc_s1_reg <= {reference_clock_in_rate_select_i, atomic_sync_i, per_channel_mode_i,
        special_code_select_i, bist_latch_enable_i, out_latch_enable_i,
        device_reset_n_i};
      misc_s2_reg <= misc_s1_reg;
      tri_s1_reg <= {input_clock_select_i, speed_range_select_i, 2'h0};
      tri_s2_reg <= tri_s1_reg;
    end
  end
  assign rst_n_pin = misc_s2_reg[0];
  assign ole_pin = misc_s2_reg[1];
  assign ble_pin = misc_s2_reg[2];
  assign special_code_select_pin = misc_s2_reg[3];
  assign pcm_pin = misc_s2_reg[4];
  assign atom_pin = misc_s2_reg[5];
  assign rate_pin = misc_s2_reg[6];
  assign ckin_pin = tri_s2_reg[5:4];
  assign spd_pin = tri_s2_reg[3:2];

  // Latch contents hold while closed; output follows bus while open
  reg [2*NUM_CH-1:0] oe_hold_reg;
  reg [NUM_CH-1:0] bist_hold_reg;
  wire [2*NUM_CH-1:0] oe_live;
  wire [NUM_CH-1:0] bist_dis_live;
  wire [NUM_CH-1:0] bist_sel;
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_sel
      assign bist_sel[g] = sel_s2_reg[2*g+1];
    end
  endgenerate
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      oe_hold_reg <= {2*NUM_CH{1'b0}};
      bist_hold_reg <= {NUM_CH{1'b1}};
    end else if (ce_i) begin
      if (!rst_n_pin) begin
        oe_hold_reg <= {2*NUM_CH{1'b0}};
        bist_hold_reg <= {NUM_CH{1'b1}};
      end else begin
        if (ole_pin) begin
          oe_hold_reg <= sel_s2_reg;
        end
        if (ble_pin) begin
          bist_hold_reg <= bist_sel;
        end
      end
    end
  end
  // Reset wins over the open path
  assign oe_live = !rst_n_pin ? {2*NUM_CH{1'b0}} :
    (ole_pin ? sel_s2_reg : oe_hold_reg);
  assign bist_dis_live = !rst_n_pin ? {NUM_CH{1'b1}} :
    (ble_pin ? bist_sel : bist_hold_reg);
  assign driver_enable_o = oe_live;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_pwr
      assign channel_power_o[g] = oe_live[2*g] | oe_live[2*g+1];
    end
  endgenerate
  assign bist_active_o = ~bist_dis_live & channel_power_o;

  // Cold re-enable settle window, host-side advisory
  reg [31:0] settle_cnt_reg;
  reg any_on_reg;
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      settle_cnt_reg <= 32'h0;
      any_on_reg <= 1'b0;
      settling_o <= 1'b0;
    end else if (ce_i) begin
      any_on_reg <= |channel_power_o;
      if (!any_on_reg && (|channel_power_o)) begin
        settle_cnt_reg <= SETTLE_CYC;
        settling_o <= 1'b1;
      end else if (settle_cnt_reg != 32'h0) begin
        settle_cnt_reg <= settle_cnt_reg - 32'h1;
        settling_o <= (settle_cnt_reg != 32'h1);
      end else begin
        settling_o <= 1'b0;
      end
    end
  end

  // Multiplier, speed range and scan reporting
  function [1:0] scan_code;
    input [1:0] tri_val;
    begin
      case (tri_val)
        `TCB_TRI_LOW: scan_code = `TCB_SCAN_LOW;
        `TCB_TRI_MID: scan_code = `TCB_SCAN_MID;
        default: scan_code = `TCB_SCAN_HIGH;
      endcase
    end
  endfunction
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      clock_multiplier_o <= `TCB_MULT_FULL;
      speed_range_o <= `TCB_TRI_LOW;
      mode_invalid_o <= 1'b0;
      scan_tri_bits_o <= 6'h00;
    end else if (ce_i) begin
      clock_multiplier_o <= rate_pin ? `TCB_MULT_HALF : `TCB_MULT_FULL;
      speed_range_o <= spd_pin;
      // Flags host misuse; half rate is reserved in the low range
      mode_invalid_o <= rate_pin & ((ckin_pin != `TCB_TRI_LOW) ||
        (spd_pin == `TCB_TRI_LOW));
      // Serial pins never appear here, only select pins
      scan_tri_bits_o <= {scan_code(ckin_pin), scan_code(spd_pin),
        scan_code({1'b0, rate_pin})};
    end
  end

  // Per-channel character selection and sync sequencer
  localparam ST_IDLE = 2'b01;
  localparam ST_SYNC = 2'b10;
  generate
    for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
      wire [8:0] pat;
      wire [1:0] ctl = ctl_s2_reg[2*g+1:2*g];
      wire [7:0] dat = dat_s2_reg[8*g+7:8*g];
      reg [1:0] st_reg;
      reg [3:0] idx_reg;
      reg [1:0] kind;
      tcb_lfsr #(.W(`TCB_LFSR_W)) u_lfsr (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(bist_active_o[g]),
        .pattern_o(pat)
      );
      always @* begin
        // Special select applies only when per-channel mode is off
        kind = ctl;
        if (!pcm_pin && ctl[0]) begin
          kind = special_code_select_pin ? `TCB_CTL_SPECIAL : `TCB_CTL_FILL;
          if (ctl[1]) begin
            kind = `TCB_CTL_SYNC;
          end
        end
      end
      always @(posedge ref_clk_i) begin
        // Power-down clear obeys the clock enable so a frozen block stays frozen
        if (rst_i || (ce_i && !channel_power_o[g])) begin
          st_reg <= ST_IDLE;
          idx_reg <= 4'h0;
          char_out_o[10*g+9:10*g] <= 10'h000;
          char_kind_o[2*g+1:2*g] <= `TCB_CTL_DATA;
          sync_active_o[g] <= 1'b0;
          sync_index_o[4*g+3:4*g] <= 4'h0;
        end else if (ce_i) begin
          sync_index_o[4*g+3:4*g] <= idx_reg;
          if (bist_active_o[g]) begin
            st_reg <= ST_IDLE;
            idx_reg <= 4'h0;
            char_out_o[10*g+9:10*g] <= {1'b0, pat};
            char_kind_o[2*g+1:2*g] <= `TCB_CTL_DATA;
            sync_active_o[g] <= 1'b0;
          end else begin
            case (st_reg)
              ST_IDLE: begin
                char_out_o[10*g+9:10*g] <= {2'b00, dat};
                char_kind_o[2*g+1:2*g] <= kind;
                sync_active_o[g] <= (kind == `TCB_CTL_SYNC);
                if (kind == `TCB_CTL_SYNC) begin
                  st_reg <= ST_SYNC;
                  idx_reg <= 4'h1;
                end
              end
              ST_SYNC: begin
                if (atom_pin || ctl == `TCB_CTL_DATA) begin
                  char_kind_o[2*g+1:2*g] <= `TCB_CTL_SYNC;
                  sync_active_o[g] <= 1'b1;
                  idx_reg <= idx_reg + 4'h1;
                  if (idx_reg == `TCB_SEQ_LEN) begin
                    st_reg <= ST_IDLE;
                    idx_reg <= 4'h0;
                  end
                end else begin
                  // Interrupted: encode what is presented now
                  st_reg <= ST_IDLE;
                  idx_reg <= 4'h0;
                  char_out_o[10*g+9:10*g] <= {2'b00, dat};
                  char_kind_o[2*g+1:2*g] <= kind;
                  sync_active_o[g] <= 1'b0;
                end
              end
              default: begin
                st_reg <= ST_IDLE;
                idx_reg <= 4'h0;
              end
            endcase
          end
        end
      end
    end
  endgenerate
endmodule

/* hdl/tcb_regs.vh */
// Constants for the transmit channel enable and self-test control block
`ifndef TCB_REGS_VH
`define TCB_REGS_VH
`define TCB_NUM_CH 4
`define TCB_SEL_W 8
`define TCB_SEQ_LEN 4'hf
`define TCB_LFSR_W 9
`define TCB_LFSR_SEED 9'h1ff
`define TCB_CTL_DATA 2'h0
`define TCB_CTL_FILL 2'h1
`define TCB_CTL_SPECIAL 2'h2
`define TCB_CTL_SYNC 2'h3
`define TCB_TRI_LOW 2'h0
`define TCB_TRI_MID 2'h1
`define TCB_TRI_HIGH 2'h2
`define TCB_SCAN_LOW 2'h0
`define TCB_SCAN_MID 2'h2
`define TCB_SCAN_HIGH 2'h3
`define TCB_MULT_FULL 5'h0a
`define TCB_MULT_HALF 5'h14
`define TCB_SETTLE_US 200
`define TCB_CLK_MHZ 200
`define TCB_SETTLE_CYC (`TCB_SETTLE_US * `TCB_CLK_MHZ)
`endif

/* hdl/tcb_lfsr.v */
// Per-channel self-test pattern generator, 511-state LFSR
`timescale 1ns/1ps
`include "tcb_regs.vh"
module tcb_lfsr #(
  parameter W = `TCB_LFSR_W
) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire run_i,
  output wire [W-1:0] pattern_o
);
  reg [W-1:0] lfsr_reg;
  wire [W-1:0] lfsr_next;
  // x^9 + x^5 + 1, maximal length 511, never reaches all zeros
  assign lfsr_next = {lfsr_reg[W-2:0], lfsr_reg[8] ^ lfsr_reg[4]};
  always @(posedge ref_clk_i) begin
    if (rst_i) begin
      lfsr_reg <= `TCB_LFSR_SEED;
    end else if (ce_i) begin
      if (run_i) begin
        lfsr_reg <= lfsr_next;
      end else begin
        lfsr_reg <= `TCB_LFSR_SEED;
      end
    end
  end
  assign pattern_o = lfsr_reg;
endmodule

/* sim/tcb_ctrl_monitor.sv */
// Port-level checker for the channel enable and self-test control block
`timescale 1ns/1ps
module tcb_ctrl_mon #(parameter NUM_CH = 4, parameter SETTLE_CYC = 20) (
  input wire ref_clk_i,
  input wire rst_i,
  input wire device_reset_n_i,
  input wire out_latch_enable_i,
  input wire bist_latch_enable_i,
  input wire [2*NUM_CH-1:0] enable_select_bus_i,
  input wire reference_clock_in_rate_select_i,
  input wire [1:0] input_clock_select_i,
  input wire [1:0] speed_range_select_i,
  input wire [2*NUM_CH-1:0] driver_enable_o,
  input wire [NUM_CH-1:0] channel_power_o,
  input wire [NUM_CH-1:0] bist_active_o,
  input wire [4:0] clock_multiplier_o,
  input wire [1:0] speed_range_o,
  input wire mode_invalid_o,
  input wire [5:0] scan_tri_bits_o
);
  wire [7:0] de = driver_enable_o;
  wire [7:0] bus = enable_select_bus_i;
  wire [3:0] odd_n = ~{bus[7], bus[5], bus[3], bus[1]};
  function [1:0] tc(input [1:0] v);
    tc = (v == 2'h0) ? 2'h0 : (v == 2'h1) ? 2'h2 : 2'h3;
  endfunction
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Config pins quiet long enough for sync plus output register
  sequence cfg_s;
    ($stable(reference_clock_in_rate_select_i) && $stable(input_clock_select_i)
      && $stable(speed_range_select_i))[*5];
  endsequence
  a_power_pair: assert property (channel_power_o == {|de[7:6], |de[5:4], |de[3:2], |de[1:0]})
    else $error("channel power differs from its driver pair");
  a_oe_pass: assert property ((out_latch_enable_i && device_reset_n_i
    && $stable(bus))[*4] |-> de == bus) else $error("open output latch not passing bus");
  a_oe_hold: assert property ((!out_latch_enable_i && device_reset_n_i)[*4] |=> $stable(de))
    else $error("closed output latch changed");
  a_oe_reset: assert property ((!device_reset_n_i)[*3] |-> de == 8'h00)
    else $error("driver enabled during device reset");
  a_bist_reset: assert property ((!device_reset_n_i)[*3] |-> bist_active_o == 4'h0)
    else $error("self-test active during device reset");
  a_bist_pass: assert property ((bist_latch_enable_i && device_reset_n_i && $stable(bus)
    && $stable(out_latch_enable_i))[*5] |-> bist_active_o == (odd_n & channel_power_o))
    else $error("open self-test latch wrong");
  a_bist_hold: assert property ((!bist_latch_enable_i && device_reset_n_i
    && $stable(channel_power_o))[*4] |-> $stable(bist_active_o))
    else $error("closed self-test latch changed");
  a_mult_rate: assert property (cfg_s |-> clock_multiplier_o ==
    (reference_clock_in_rate_select_i ? 5'h14 : 5'h0a)) else $error("multiplier wrong");
  a_range_pass: assert property (cfg_s |-> speed_range_o == speed_range_select_i)
    else $error("speed range wrong");
  a_mode_check: assert property (cfg_s |-> mode_invalid_o == (reference_clock_in_rate_select_i
    && (input_clock_select_i != 2'h0 || speed_range_select_i == 2'h0)))
    else $error("invalid mode flag wrong");
  a_scan_tri: assert property (cfg_s |-> scan_tri_bits_o[5:2] ==
    {tc(input_clock_select_i), tc(speed_range_select_i)}) else $error("scan codes wrong");
endmodule
bind tcb_ctrl tcb_ctrl_mon #(.NUM_CH(NUM_CH), .SETTLE_CYC(SETTLE_CYC)) mon_i (.ref_clk_i,
  .rst_i, .device_reset_n_i, .out_latch_enable_i, .bist_latch_enable_i, .enable_select_bus_i,
  .reference_clock_in_rate_select_i, .input_clock_select_i, .speed_range_select_i, .driver_enable_o,
  .channel_power_o, .bist_active_o, .clock_multiplier_o, .speed_range_o, .mode_invalid_o,
  .scan_tri_bits_o);

/* sim/tcb_host.sv */
// Host-side model driving configuration pins and character data
`timescale 1ns/1ps
module tcb_host (
  input wire ref_clk_i,
  input wire half_i,
  input wire [1:0] speed_i,
  output reg reference_clock_in_rate_select_o = 1'b0,
  output reg [1:0] input_clock_select_o = 2'h0,
  output reg [1:0] speed_range_select_o = 2'h2,
  output reg [31:0] tx_data_o = 32'h0
);
  always @(posedge ref_clk_i) begin
    #1;
    reference_clock_in_rate_select_o = half_i;
    // Half rate only with reference-clocked inputs
    input_clock_select_o = half_i ? 2'h0 : speed_i;
    speed_range_select_o = speed_i;
    tx_data_o = tx_data_o + 32'h01010101;
  end
endmodule

/* sim/tb.sv */
// Self-checking bench for the channel enable and self-test control block
`timescale 1ns/1ps
module tb;
  reg ref_clk_i = 0, rst_i = 1, dev_n = 0, ole = 1, ble = 0, pcm = 1, atom = 1, scs = 1, half = 0;
  reg [7:0] bus = 8'hff, ctl = 8'h00, oe_m = 8'h00, bi_m = 8'hff;
  reg [1:0] spd = 2'h2;
  reg [9:0] v;
  wire rate, inv, settle;
  wire [1:0] cks, spo, rng;
  wire [31:0] dat;
  wire [15:0] six;
  wire [7:0] de, kind;
  wire [3:0] pw, ba, sa;
  wire [39:0] co;
  wire [4:0] mult;
  wire [5:0] scan;
  integer seed = 26202, mismatches = 0, n_checks = 0, i;
  always #2.5 ref_clk_i = ~ref_clk_i;
  tcb_host tcb_host_i (.ref_clk_i, .half_i(half), .speed_i(spd), .reference_clock_in_rate_select_o(rate),
    .input_clock_select_o(cks), .speed_range_select_o(spo), .tx_data_o(dat));
  tcb_ctrl #(.SETTLE_CYC(20)) tcb_ctrl_i (.ref_clk_i, .rst_i, .ce_i(1'b1),
    .device_reset_n_i(dev_n), .out_latch_enable_i(ole), .bist_latch_enable_i(ble),
    .enable_select_bus_i(bus), .tx_ctrl_in_i(ctl), .tx_data_in_i(dat),
    .special_code_select_i(scs), .per_channel_mode_i(pcm), .atomic_sync_i(atom),
    .reference_clock_in_rate_select_i(rate), .input_clock_select_i(cks), .speed_range_select_i(spo),
    .driver_enable_o(de), .channel_power_o(pw), .bist_active_o(ba), .char_out_o(co),
    .char_kind_o(kind), .sync_active_o(sa), .sync_index_o(six), .clock_multiplier_o(mult),
    .speed_range_o(rng), .mode_invalid_o(inv), .settling_o(settle), .scan_tri_bits_o(scan));
  function [3:0] pwr(input [7:0] e);
    pwr = {|e[7:6], |e[5:4], |e[3:2], |e[1:0]};
  endfunction
  function [1:0] tc(input [1:0] t);
    tc = (t == 2'h0) ? 2'h0 : (t == 2'h1) ? 2'h2 : 2'h3;
  endfunction
  task step(input integer n);
    begin
      repeat (n) @(posedge ref_clk_i);
      #1;
    end
  endtask
  task check(input [39:0] g, input [39:0] e);
    begin
      n_checks = n_checks + 1;
      if (g !== e) begin
        mismatches = mismatches + 1;
        $display("mismatch at %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Bus write mirrored into the latch model wherever the latch is open
  task put(input [7:0] b);
    begin
      bus = b;
      if (ole) oe_m = b;
      if (ble) bi_m = b;
      step(4);
      check(de, oe_m);
      check(pw, pwr(oe_m));
      check(ba, ~{bi_m[7], bi_m[5], bi_m[3], bi_m[1]} & pwr(oe_m));
    end
  endtask
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    #15000;
    mismatches = mismatches + 1;
    stop_test;
  end
  initial begin
    step(4);
    rst_i = 0;
    dev_n = 1;
    put(8'hff);
    check(settle, 1);
    for (i = 0; i < 6; i = i + 1) put($random(seed));
    check(settle, 0);
    ole = 0;
    step(1);
    for (i = 0; i < 4; i = i + 1) put($random(seed));
    ole = 1;
    ble = 1;
    for (i = 0; i < 6; i = i + 1) put($random(seed));
    ble = 0;
    step(1);
    for (i = 0; i < 4; i = i + 1) put($random(seed));
    $display("test latches done");
    ble = 1;
    put(8'h55);
    ble = 0;
    step(2);
    v = co[9:0];
    ctl = $random(seed);
    step(511);
    check(co[9:0], v);
    $display("test pattern done");
    ole = 0;
    dev_n = 0;
    oe_m = 8'h00;
    bi_m = 8'hff;
    put(8'hff);
    dev_n = 1;
    put(8'hff);
    $display("test device reset done");
    for (i = 0; i < 6; i = i + 1) begin
      half = i % 2;
      spd = i / 2;
      step(8);
      check(mult, half ? 5'h14 : 5'h0a);
      check(rng, spd);
      check(inv, half && (cks != 2'h0 || spd == 2'h0));
      check(scan[5:2], {tc(cks), tc(spd)});
    end
    $display("test config done");
    ole = 1;
    ble = 1;
    put(8'hff);
    for (i = 0; i < 2; i = i + 1) begin
      ctl = i ? 8'h12 : 8'h24;
      step(4);
      check(kind, ctl);
    end
    ctl = 8'hff;
    step(1);
    ctl = 8'h55;
    step(6);
    check(sa, 4'hf);
    check(six, 16'h4444);
    step(18);
    check(sa, 4'h0);
    check(kind, 8'h55);
    atom = 0;
    ctl = 8'hff;
    step(1);
    ctl = 8'h00;
    step(6);
    check(sa, 4'hf);
    ctl = 8'h55;
    step(4);
    check(sa, 4'h0);
    check(kind, 8'h55);
    pcm = 0;
    scs = 1;
    step(4);
    check(kind, 8'haa);
    scs = 0;
    step(4);
    check(kind, 8'h55);
    $display("test codes done");
    stop_test;
  end
endmodule
